// >>> hdl/ucf_image_latch.sv
// default image selection and holding for the memory-loaded flags
`timescale 1ns/10ps
module ucf_image_latch (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          load,
   input  wire logic          eeprom_present,
   input  wire logic          otp_programmed,
   input  ucf_pkg::ucf_flags_t eeprom_flags,
   input  ucf_pkg::ucf_flags_t otp_flags,
   output ucf_pkg::ucf_flags_t image,
   output logic               load_done
);
   import ucf_pkg::*;

   ucf_flags_t next_image;

   always_comb begin
      next_image = UCF_FLAGS_FALLBACK;
      if (eeprom_present) begin
         next_image = eeprom_flags;
      end else if (otp_programmed) begin
         next_image = otp_flags;
         next_image.power_mode_select = UCF_POWER_NOMEM;
      end
   end

   // the image is kept so that later bus resets restore the last one loaded
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         image <= UCF_FLAGS_FALLBACK;
      end else if (load) begin
         image <= next_image;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         load_done <= 1'b0;
      end else begin
         load_done <= load;
      end
   end
endmodule : ucf_image_latch

// >>> hdl/ucf_rst_sync.sv
// reset release synchroniser
`timescale 1ns/10ps
module ucf_rst_sync (
   input  wire logic clk,
   input  wire logic rst_async_n,
   output logic      rst_n
);
   logic meta_n;

   // assertion is immediate, release waits two edges to avoid metastable exit
   always_ff @(posedge clk or negedge rst_async_n) begin
      if (!rst_async_n) begin
         meta_n <= 1'b0;
         rst_n  <= 1'b0;
      end else begin
         meta_n <= 1'b1;
         rst_n  <= meta_n;
      end
   end
endmodule : ucf_rst_sync

// >>> hdl/ucf_usb_device_config_0.sv
// usb device configuration register 0 with avalon-mm slave and its controls
// How it works
// - bit 30 enables link power management; the capability output follows it
// - bit 29 low keeps the suspend output from asserting; high lets it assert
// - bits 15:13 choose connect speed, 000 high, 001 full, reset 000
// - writing one to bit 10 resets the bulk-in transmitter; self clearing
// - writing one to bit 9 resets the bulk-out receiver; self clearing
// - empty fifo on in token: zero-length reply if bit 6 low, nak if high
// - bit 5 high limits transmit bursts to the burst cap value
// - bit 4 reads the data-line mapping, one means pins swapped
// - bit 2 reports remote wakeup support for device and function features
// - bit 1 reports power mode: zero bus powered, one self powered
// - sync loss stalls bulk-out pipe when bit 0 low, not when high
// - lpm, suspend and wakeup defaults: eeprom, else otp, else one
// - swap default: eeprom, else otp, else zero
// - power mode default: eeprom only, else one; otp ignored
// - usb or lite reset restores memory fields to last loaded image
// - lpm, suspend, speed, wakeup and power fields survive protected resets
// - register at 080h; neighbour at 084h is not part of this block
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/10ps
module ucf_usb_device_config_0 #(
   parameter int ADDR_W  = 8,
   parameter int BURST_W = 8
) (
   input  wire logic                CLK,
   input  wire logic                RST_B,
   input  wire logic [ADDR_W-1:0]   AVS_ADDRESS,
   input  wire logic                AVS_READ,
   input  wire logic                AVS_WRITE,
   input  wire logic [31:0]         AVS_WRITEDATA,
   input  wire logic [3:0]          AVS_BYTEENABLE,
   output logic      [31:0]         AVS_READDATA,
   output logic                     AVS_WAITREQUEST,
   input  wire logic                EEPROM_PRESENT,
   input  wire logic                OTP_PROGRAMMED,
   input  ucf_pkg::ucf_flags_t      EEPROM_FLAGS,
   input  ucf_pkg::ucf_flags_t      OTP_FLAGS,
   input  wire logic                IMAGE_LOAD,
   input  wire logic                USB_RESET,
   input  wire logic                LITE_SOFT_RESET,
   input  wire logic                RESET_PROTECT,
   input  wire logic                SUSPEND_COND,
   output logic                     SUSPEND_OUT_N,
   output logic                     LINK_PM_CAPABLE,
   output logic      [2:0]          CONNECT_SPEED_SELECT,
   output logic                     CONNECT_FULL_SPEED,
   output logic                     BULK_IN_TRANSMITTER_RESET,
   output logic                     BULK_OUT_RECEIVER_RESET,
   input  wire logic                IN_TOKEN,
   input  wire logic                RX_FIFO_EMPTY,
   output logic                     REPLY_ZLP,
   output logic                     REPLY_NAK,
   input  wire logic [BURST_W-1:0]  BURST_CAP,
   output logic                     BURST_LIMIT_ACTIVE,
   output logic      [BURST_W-1:0]  BURST_LIMIT,
   output logic                     DATA_LINE_SWAP,
   output logic                     REMOTE_WAKE_SUPPORT,
   output logic                     SELF_POWERED,
   input  wire logic                SYNC_LOSS,
   output logic                     STALL_BULK_OUT
);
   import ucf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // elaboration checks
   if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must reach the register offset");
   end
   if (BURST_W < 1) begin : g_bad_burst
      $error("BURST_W must be at least one");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   logic           rst_n;
   ucf_bus_state_t bus_state;
   ucf_cfg_t       cfg;
   ucf_flags_t     image;
   logic           image_done;
   logic           hit;
   logic           wr_go;
   logic           bus_reset;
   logic           keep;

   function automatic logic is_cfg0(input logic [ADDR_W-1:0] a);
      return a == ADDR_W'(UCF_CFG0_OFFSET);
   endfunction : is_cfg0

   function automatic logic lane(input logic [3:0] be, input int bit_pos);
      return be[bit_pos / 8];
   endfunction : lane

   ////////////////////////////////////////////////////////////////////////////////
   // submodules
   ucf_rst_sync u_rst (
      .clk         (CLK),
      .rst_async_n (RST_B),
      .rst_n       (rst_n)
   );

   ucf_image_latch u_image (
      .clk            (CLK),
      .rst_n          (rst_n),
      .load           (IMAGE_LOAD),
      .eeprom_present (EEPROM_PRESENT),
      .otp_programmed (OTP_PROGRAMMED),
      .eeprom_flags   (EEPROM_FLAGS),
      .otp_flags      (OTP_FLAGS),
      .image          (image),
      .load_done      (image_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // avalon slave: one wait state, answer on the second edge of a request
   assign hit       = is_cfg0(AVS_ADDRESS);
   assign wr_go     = (bus_state == UCF_BUS_ACK) && AVS_WRITE && hit;
   assign bus_reset = USB_RESET || LITE_SOFT_RESET;
   assign keep      = bus_reset && RESET_PROTECT;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         bus_state       <= UCF_BUS_IDLE;
         AVS_WAITREQUEST <= 1'b1;
      end else begin
         case (bus_state)
            UCF_BUS_IDLE: begin
               if (AVS_READ || AVS_WRITE) begin
                  bus_state       <= UCF_BUS_ACK;
                  AVS_WAITREQUEST <= 1'b0;
               end
            end
            UCF_BUS_ACK: begin
               bus_state       <= UCF_BUS_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
            default: begin
               bus_state       <= UCF_BUS_IDLE;
               AVS_WAITREQUEST <= 1'b1;
            end
         endcase
      end
   end

   // unmapped addresses, the 084h neighbour included, read as zero
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         AVS_READDATA <= 32'h0000_0000;
      end else if (bus_state == UCF_BUS_IDLE && AVS_READ) begin
         AVS_READDATA <= hit ? ucf_pack(cfg) : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // memory-loaded flags; image load wins, then bus reset, then software
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg.flags <= UCF_FLAGS_FALLBACK;
      end else if (image_done) begin
         cfg.flags <= image;
      end else if (bus_reset) begin
         cfg.flags.stored_data_line_swap <= image.stored_data_line_swap;
         if (!keep) begin
            cfg.flags.link_pm_capable     <= image.link_pm_capable;
            cfg.flags.suspend_allow       <= image.suspend_allow;
            cfg.flags.remote_wake_support <= image.remote_wake_support;
            cfg.flags.power_mode_select   <= image.power_mode_select;
         end
      end else if (wr_go) begin
         // swap bit is read only, so it is never written here
         if (lane(AVS_BYTEENABLE, UCF_LPM_BIT)) begin
            cfg.flags.link_pm_capable <= AVS_WRITEDATA[UCF_LPM_BIT];
            cfg.flags.suspend_allow   <= AVS_WRITEDATA[UCF_SUSP_BIT];
         end
         if (lane(AVS_BYTEENABLE, UCF_WAKE_BIT)) begin
            cfg.flags.remote_wake_support <= AVS_WRITEDATA[UCF_WAKE_BIT];
            cfg.flags.power_mode_select   <= AVS_WRITEDATA[UCF_POWER_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // connect speed, protected like the memory flags
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg.connect_speed_select <= UCF_SPEED_RST;
      end else if (bus_reset) begin
         if (!keep) begin
            cfg.connect_speed_select <= UCF_SPEED_RST;
         end
      end else if (wr_go && lane(AVS_BYTEENABLE, UCF_SPEED_LSB)) begin
         cfg.connect_speed_select <= AVS_WRITEDATA[UCF_SPEED_MSB:UCF_SPEED_LSB];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // unprotected controls always return to defaults on a bus reset
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg.empty_bulk_in_reply   <= UCF_REPLY_RST;
         cfg.burst_limit_enable    <= UCF_BURST_RST;
         cfg.no_stall_on_sync_loss <= UCF_NOSTALL_RST;
      end else if (bus_reset) begin
         cfg.empty_bulk_in_reply   <= UCF_REPLY_RST;
         cfg.burst_limit_enable    <= UCF_BURST_RST;
         cfg.no_stall_on_sync_loss <= UCF_NOSTALL_RST;
      end else if (wr_go && lane(AVS_BYTEENABLE, UCF_REPLY_BIT)) begin
         cfg.empty_bulk_in_reply   <= AVS_WRITEDATA[UCF_REPLY_BIT];
         cfg.burst_limit_enable    <= AVS_WRITEDATA[UCF_BURST_BIT];
         cfg.no_stall_on_sync_loss <= AVS_WRITEDATA[UCF_NOSTALL_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // self-clearing reset bits: high for exactly the cycle after the write
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         cfg.bulk_in_transmitter_rst <= UCF_SC_RST;
         cfg.bulk_out_receiver_rst   <= UCF_SC_RST;
      end else begin
         cfg.bulk_in_transmitter_rst <= wr_go && lane(AVS_BYTEENABLE, UCF_TXRST_BIT)
                                        && AVS_WRITEDATA[UCF_TXRST_BIT];
         cfg.bulk_out_receiver_rst   <= wr_go && lane(AVS_BYTEENABLE, UCF_RXRST_BIT)
                                        && AVS_WRITEDATA[UCF_RXRST_BIT];
      end
   end

   assign BULK_IN_TRANSMITTER_RESET = cfg.bulk_in_transmitter_rst;
   assign BULK_OUT_RECEIVER_RESET   = cfg.bulk_out_receiver_rst;

   ////////////////////////////////////////////////////////////////////////////////
   // level controls toward the usb core, one cycle behind the register
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         SUSPEND_OUT_N        <= 1'b1;
         LINK_PM_CAPABLE      <= 1'b0;
         CONNECT_SPEED_SELECT <= UCF_SPEED_RST;
         CONNECT_FULL_SPEED   <= 1'b0;
         DATA_LINE_SWAP       <= 1'b0;
         REMOTE_WAKE_SUPPORT  <= 1'b0;
         SELF_POWERED         <= 1'b0;
      end else begin
         SUSPEND_OUT_N        <= !(SUSPEND_COND && cfg.flags.suspend_allow);
         LINK_PM_CAPABLE      <= cfg.flags.link_pm_capable;
         CONNECT_SPEED_SELECT <= cfg.connect_speed_select;
         CONNECT_FULL_SPEED   <= cfg.connect_speed_select == UCF_SPEED_FULL;
         DATA_LINE_SWAP       <= cfg.flags.stored_data_line_swap;
         REMOTE_WAKE_SUPPORT  <= cfg.flags.remote_wake_support;
         SELF_POWERED         <= cfg.flags.power_mode_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // empty-fifo reply choice, one pulse per in token
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         REPLY_ZLP <= 1'b0;
         REPLY_NAK <= 1'b0;
      end else begin
         REPLY_ZLP <= IN_TOKEN && RX_FIFO_EMPTY && !cfg.empty_bulk_in_reply;
         REPLY_NAK <= IN_TOKEN && RX_FIFO_EMPTY &&  cfg.empty_bulk_in_reply;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // burst limit: zero means no limit, so the cap is only passed when enabled
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         BURST_LIMIT_ACTIVE <= 1'b0;
         BURST_LIMIT        <= '0;
      end else begin
         BURST_LIMIT_ACTIVE <= cfg.burst_limit_enable;
         BURST_LIMIT        <= cfg.burst_limit_enable ? BURST_CAP : '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // bulk-out stall on sync loss
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         STALL_BULK_OUT <= 1'b0;
      end else begin
         STALL_BULK_OUT <= SYNC_LOSS && !cfg.no_stall_on_sync_loss;
      end
   end

endmodule : ucf_usb_device_config_0

// >>> pkg/ucf_pkg.sv
// constants, field layout and carrier types of the usb device configuration register 0
package ucf_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // register map
   localparam logic [7:0] UCF_CFG0_OFFSET = 8'h80;
   localparam logic [7:0] UCF_CFG1_OFFSET = 8'h84;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int UCF_LPM_BIT     = 30;
   localparam int UCF_SUSP_BIT    = 29;
   localparam int UCF_SPEED_MSB   = 15;
   localparam int UCF_SPEED_LSB   = 13;
   localparam int UCF_TXRST_BIT   = 10;
   localparam int UCF_RXRST_BIT   = 9;
   localparam int UCF_REPLY_BIT   = 6;
   localparam int UCF_BURST_BIT   = 5;
   localparam int UCF_SWAP_BIT    = 4;
   localparam int UCF_WAKE_BIT    = 2;
   localparam int UCF_POWER_BIT   = 1;
   localparam int UCF_NOSTALL_BIT = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // encodings and reset values
   localparam logic [2:0] UCF_SPEED_HIGH  = 3'h0;
   localparam logic [2:0] UCF_SPEED_FULL  = 3'h1;
   localparam logic [2:0] UCF_SPEED_RST   = 3'h0;
   localparam logic       UCF_REPLY_RST   = 1'h0;
   localparam logic       UCF_BURST_RST   = 1'h0;
   localparam logic       UCF_NOSTALL_RST = 1'h0;
   localparam logic       UCF_SC_RST      = 1'h0;
   localparam logic       UCF_POWER_NOMEM = 1'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // carrier types
   typedef struct packed {
      logic link_pm_capable;
      logic suspend_allow;
      logic stored_data_line_swap;
      logic remote_wake_support;
      logic power_mode_select;
   } ucf_flags_t;

   localparam ucf_flags_t UCF_FLAGS_FALLBACK = '{
      link_pm_capable:       1'h1,
      suspend_allow:         1'h1,
      stored_data_line_swap: 1'h0,
      remote_wake_support:   1'h1,
      power_mode_select:     1'h1
   };

   typedef struct packed {
      ucf_flags_t flags;
      logic [2:0] connect_speed_select;
      logic       bulk_in_transmitter_rst;
      logic       bulk_out_receiver_rst;
      logic       empty_bulk_in_reply;
      logic       burst_limit_enable;
      logic       no_stall_on_sync_loss;
   } ucf_cfg_t;

   typedef enum logic [1:0] {
      UCF_BUS_IDLE = 2'h0,
      UCF_BUS_ACK  = 2'h1
   } ucf_bus_state_t;

   // word image of the register; unlisted bits stay zero
   function automatic logic [31:0] ucf_pack(input ucf_cfg_t c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[UCF_LPM_BIT]                   = c.flags.link_pm_capable;
      w[UCF_SUSP_BIT]                  = c.flags.suspend_allow;
      w[UCF_SPEED_MSB:UCF_SPEED_LSB]   = c.connect_speed_select;
      w[UCF_TXRST_BIT]                 = c.bulk_in_transmitter_rst;
      w[UCF_RXRST_BIT]                 = c.bulk_out_receiver_rst;
      w[UCF_REPLY_BIT]                 = c.empty_bulk_in_reply;
      w[UCF_BURST_BIT]                 = c.burst_limit_enable;
      w[UCF_SWAP_BIT]                  = c.flags.stored_data_line_swap;
      w[UCF_WAKE_BIT]                  = c.flags.remote_wake_support;
      w[UCF_POWER_BIT]                 = c.flags.power_mode_select;
      w[UCF_NOSTALL_BIT]               = c.no_stall_on_sync_loss;
      return w;
   endfunction : ucf_pack

endpackage : ucf_pkg

// >>> tb/ucf_far_model.sv
// host and fifo side model: in tokens and sync-loss reports after a chosen delay
`timescale 1ns/10ps
module ucf_far_model (
   input  wire logic       clk,
   input  wire logic [1:0] req,
   input  wire logic [3:0] lag,
   output logic            in_token,
   output logic            sync_loss
);
   logic [1:0] pend;
   logic [3:0] wait_cnt;
   initial begin
      in_token = 1'b0;
      sync_loss = 1'b0;
      pend = 2'h0;
      wait_cnt = 4'h0;
   end
   // one event in flight at a time; a lag of zero answers promptly
   always @(posedge clk) begin
      in_token <= 1'b0;
      sync_loss <= 1'b0;
      if (pend == 2'h0) begin
         pend <= req;
         wait_cnt <= lag;
      end else if (wait_cnt == 4'h0) begin
         in_token <= pend[0];
         sync_loss <= pend[1];
         pend <= 2'h0;
      end else begin
         wait_cnt <= wait_cnt - 4'h1;
      end
   end
endmodule : ucf_far_model

// >>> tb/ucf_usb_device_config_0_monitor.sv
// concurrent checks on the ports of the usb device configuration register 0
`timescale 1ns/10ps
module ucf_usb_device_config_0_monitor
   import ucf_pkg::*;
#(
   parameter int ADDR_W  = 8,
   parameter int BURST_W = 8
) (
   input wire logic               CLK,
   input wire logic               RST_B,
   input wire logic [ADDR_W-1:0]  AVS_ADDRESS,
   input wire logic               AVS_READ,
   input wire logic               AVS_WRITE,
   input wire logic [31:0]        AVS_WRITEDATA,
   input wire logic [3:0]         AVS_BYTEENABLE,
   input wire logic [31:0]        AVS_READDATA,
   input wire logic               AVS_WAITREQUEST,
   input wire logic               SUSPEND_COND,
   input wire logic               SUSPEND_OUT_N,
   input wire logic [2:0]         CONNECT_SPEED_SELECT,
   input wire logic               CONNECT_FULL_SPEED,
   input wire logic               BULK_IN_TRANSMITTER_RESET,
   input wire logic               BULK_OUT_RECEIVER_RESET,
   input wire logic               IN_TOKEN,
   input wire logic               RX_FIFO_EMPTY,
   input wire logic               REPLY_ZLP,
   input wire logic               REPLY_NAK,
   input wire logic [BURST_W-1:0] BURST_CAP,
   input wire logic               BURST_LIMIT_ACTIVE,
   input wire logic [BURST_W-1:0] BURST_LIMIT,
   input wire logic               SYNC_LOSS,
   input wire logic               STALL_BULK_OUT
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   ////////////////////////////////////////
   // the write lands at the edge where waitrequest is seen low
   sequence s_land;
      !AVS_WAITREQUEST && AVS_WRITE && AVS_ADDRESS == ADDR_W'(UCF_CFG0_OFFSET) && AVS_BYTEENABLE[1];
   endsequence
   sequence s_answer;
      !AVS_WAITREQUEST && AVS_READ;
   endsequence
   AST_SC_TX: assert property (s_land ##0 AVS_WRITEDATA[UCF_TXRST_BIT] |=> BULK_IN_TRANSMITTER_RESET ##1 !BULK_IN_TRANSMITTER_RESET)
      else $error("transmitter reset pulse wrong");
   AST_SC_RX: assert property (s_land ##0 AVS_WRITEDATA[UCF_RXRST_BIT] |=> BULK_OUT_RECEIVER_RESET ##1 !BULK_OUT_RECEIVER_RESET)
      else $error("receiver reset pulse wrong");
   AST_REPLY: assert property (IN_TOKEN && RX_FIFO_EMPTY |=> REPLY_ZLP ^ REPLY_NAK)
      else $error("no single reply to in token");
   AST_NO_REPLY: assert property (!(IN_TOKEN && RX_FIFO_EMPTY) |=> !REPLY_ZLP && !REPLY_NAK)
      else $error("reply without cause");
   AST_STALL: assert property (!SYNC_LOSS |=> !STALL_BULK_OUT)
      else $error("stall without sync loss");
   AST_SUSPEND: assert property (!SUSPEND_COND |=> SUSPEND_OUT_N)
      else $error("suspend without condition");
   AST_FULL: assert property (CONNECT_FULL_SPEED == (CONNECT_SPEED_SELECT == UCF_SPEED_FULL))
      else $error("full speed flag disagrees with field");
   AST_BURST: assert property (BURST_LIMIT == (BURST_LIMIT_ACTIVE ? $past(BURST_CAP) : '0))
      else $error("burst limit wrong");
   AST_RSV: assert property (s_answer |-> (AVS_READDATA & 32'h9FFF_1988) == 32'h0000_0000)
      else $error("reserved bits read nonzero");
   AST_UNMAP: assert property (s_answer ##0 AVS_ADDRESS != ADDR_W'(UCF_CFG0_OFFSET) |-> AVS_READDATA == 32'h0000_0000)
      else $error("unmapped read nonzero");
endmodule : ucf_usb_device_config_0_monitor
bind ucf_usb_device_config_0 ucf_usb_device_config_0_monitor #(.ADDR_W(ADDR_W), .BURST_W(BURST_W)) u_mon (
   .CLK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
   .AVS_WAITREQUEST, .SUSPEND_COND, .SUSPEND_OUT_N, .CONNECT_SPEED_SELECT, .CONNECT_FULL_SPEED,
   .BULK_IN_TRANSMITTER_RESET, .BULK_OUT_RECEIVER_RESET, .IN_TOKEN, .RX_FIFO_EMPTY, .REPLY_ZLP, .REPLY_NAK,
   .BURST_CAP, .BURST_LIMIT_ACTIVE, .BURST_LIMIT, .SYNC_LOSS, .STALL_BULK_OUT);

// >>> tb/ucf_usb_device_config_0_test.sv
// self-checking bench for the usb device configuration register 0
`timescale 1ns/10ps
module ucf_usb_device_config_0_test;
   import ucf_pkg::*;
   logic        CLK = 1'b0, RST_B = 1'b0, AVS_READ = 1'b0, AVS_WRITE = 1'b0, AVS_WAITREQUEST;
   logic [7:0]  AVS_ADDRESS = 8'h00, BURST_CAP = 8'hA5, BURST_LIMIT;
   logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, rd;
   logic [3:0]  AVS_BYTEENABLE = 4'hF, far_lag = 4'h0;
   logic        EEPROM_PRESENT = 1'b0, OTP_PROGRAMMED = 1'b0, IMAGE_LOAD = 1'b0, USB_RESET = 1'b0;
   ucf_flags_t  EEPROM_FLAGS = '0, OTP_FLAGS = '0;
   logic        LITE_SOFT_RESET = 1'b0, RESET_PROTECT = 1'b0, SUSPEND_COND = 1'b0, RX_FIFO_EMPTY = 1'b1;
   logic [2:0]  CONNECT_SPEED_SELECT;
   logic [1:0]  far_req = 2'h0;
   logic        IN_TOKEN, SYNC_LOSS, SUSPEND_OUT_N, LINK_PM_CAPABLE, CONNECT_FULL_SPEED, REPLY_ZLP, REPLY_NAK;
   logic        BULK_IN_TRANSMITTER_RESET, BULK_OUT_RECEIVER_RESET, BURST_LIMIT_ACTIVE, DATA_LINE_SWAP;
   logic        REMOTE_WAKE_SUPPORT, SELF_POWERED, STALL_BULK_OUT;
   int          bad_count = 0, n_compared = 0, cycles = 0;
   ucf_usb_device_config_0 u_dut (.CLK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE,
      .AVS_READDATA, .AVS_WAITREQUEST, .EEPROM_PRESENT, .OTP_PROGRAMMED, .EEPROM_FLAGS, .OTP_FLAGS, .IMAGE_LOAD,
      .USB_RESET, .LITE_SOFT_RESET, .RESET_PROTECT, .SUSPEND_COND, .SUSPEND_OUT_N, .LINK_PM_CAPABLE,
      .CONNECT_SPEED_SELECT, .CONNECT_FULL_SPEED, .BULK_IN_TRANSMITTER_RESET, .BULK_OUT_RECEIVER_RESET, .IN_TOKEN,
      .RX_FIFO_EMPTY, .REPLY_ZLP, .REPLY_NAK, .BURST_CAP, .BURST_LIMIT_ACTIVE, .BURST_LIMIT, .DATA_LINE_SWAP,
      .REMOTE_WAKE_SUPPORT, .SELF_POWERED, .SYNC_LOSS, .STALL_BULK_OUT);
   ucf_far_model u_far (.clk(CLK), .req(far_req), .lag(far_lag), .in_token(IN_TOKEN), .sync_loss(SYNC_LOSS));
   always #4 CLK = ~CLK;
   // whole run is a few hundred cycles; the ceiling only catches a hung wait
   always @(posedge CLK) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         final_report;
      end
   end
   ////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= wr;
      AVS_READ <= !wr;
      do @(posedge CLK); while (AVS_WAITREQUEST !== 1'b0);
      rd = AVS_READDATA;
      AVS_WRITE <= 1'b0;
      AVS_READ <= 1'b0;
   endtask : bus
   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk
   task wrsc(input logic [31:0] d);
      bus(1'b1, 8'h80, d);
      #1 chk({30'h0, BULK_IN_TRANSMITTER_RESET, BULK_OUT_RECEIVER_RESET}, {30'h0, d[10], d[9]});
      @(posedge CLK);
      #1 chk({30'h0, BULK_IN_TRANSMITTER_RESET, BULK_OUT_RECEIVER_RESET}, 32'h0);
   endtask : wrsc
   task outs(input logic [31:0] exp);
      repeat (3) @(posedge CLK);
      #1 chk({15'h0, LINK_PM_CAPABLE, CONNECT_SPEED_SELECT, CONNECT_FULL_SPEED, DATA_LINE_SWAP,
         REMOTE_WAKE_SUPPORT, SELF_POWERED, BURST_LIMIT_ACTIVE, BURST_LIMIT}, exp);
   endtask : outs
   task img(input logic ee, input logic otp, input ucf_flags_t ef, input ucf_flags_t of, input logic [31:0] exp);
      @(posedge CLK);
      EEPROM_PRESENT <= ee;
      OTP_PROGRAMMED <= otp;
      EEPROM_FLAGS <= ef;
      OTP_FLAGS <= of;
      IMAGE_LOAD <= 1'b1;
      @(posedge CLK);
      IMAGE_LOAD <= 1'b0;
      repeat (2) @(posedge CLK);
      rdchk(8'h80, exp);
   endtask : img
   task breset(input logic lite, input logic prot, input logic [31:0] exp);
      @(posedge CLK);
      RESET_PROTECT <= prot;
      USB_RESET <= !lite;
      LITE_SOFT_RESET <= lite;
      @(posedge CLK);
      RESET_PROTECT <= 1'b0;
      USB_RESET <= 1'b0;
      LITE_SOFT_RESET <= 1'b0;
      rdchk(8'h80, exp);
   endtask : breset
   // collects {zlp, nak, stall} over a window wide enough for the slowest far-side lag
   task far(input logic [1:0] req, input logic [3:0] lag, input logic [31:0] exp);
      logic [2:0] seen;
      seen = 3'h0;
      @(posedge CLK);
      far_req <= req;
      far_lag <= lag;
      @(posedge CLK);
      far_req <= 2'h0;
      repeat (20) begin
         @(posedge CLK);
         #1 seen = seen | {REPLY_ZLP, REPLY_NAK, STALL_BULK_OUT};
      end
      chk({29'h0, seen}, exp);
   endtask : far
   task susp(input logic [31:0] exp);
      @(posedge CLK);
      SUSPEND_COND <= 1'b1;
      repeat (3) @(posedge CLK);
      #1 chk({31'h0, SUSPEND_OUT_N}, exp);
      @(posedge CLK);
      SUSPEND_COND <= 1'b0;
   endtask : susp
   task final_report;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report
   ////////////////////////////////////////
   initial begin
      repeat (5) @(posedge CLK);
      RST_B <= 1'b1;
      repeat (2) @(posedge CLK);
      rdchk(8'h80, 32'h6000_0006);
      outs(32'h0001_0600);
      img(1'b1, 1'b0, 5'h04, 5'h1B, 32'h0000_0010);
      img(1'b0, 1'b1, 5'h04, 5'h0C, 32'h2000_0012);
      img(1'b0, 1'b0, 5'h04, 5'h0C, 32'h6000_0006);
      img(1'b1, 1'b0, 5'h04, 5'h1B, 32'h0000_0010);
      wrsc(32'hFFFF_FFFF);
      rdchk(8'h80, 32'h6000_E077);
      outs(32'h0001_EFA5);
      far(2'h1, 4'h0, 32'h0000_0002);
      far(2'h2, 4'h5, 32'h0000_0000);
      susp(32'h0000_0000);
      breset(1'b0, 1'b0, 32'h0000_0010);
      wrsc(32'hFFFF_FFFF);
      breset(1'b1, 1'b1, 32'h6000_E016);
      wrsc(32'h0000_2000);
      rdchk(8'h80, 32'h0000_2010);
      outs(32'h0000_3800);
      far(2'h1, 4'h5, 32'h0000_0004);
      far(2'h2, 4'h0, 32'h0000_0001);
      @(posedge CLK);
      RX_FIFO_EMPTY <= 1'b0;
      far(2'h1, 4'h0, 32'h0000_0000);
      susp(32'h0000_0001);
      AVS_BYTEENABLE <= 4'h2;
      wrsc(32'hFFFF_FFFF);
      rdchk(8'h80, 32'h0000_E010);
      AVS_BYTEENABLE <= 4'hF;
      bus(1'b1, 8'h84, 32'hFFFF_FFFF);
      rdchk(8'h84, 32'h0000_0000);
      rdchk(8'h80, 32'h0000_E010);
      final_report;
   end
endmodule : ucf_usb_device_config_0_test
